// ### common/crsec_pkg.sv
// Package: constants, types and register map of the code-memory protection block
package crsec_pkg;
   // ****************************************************************
   // Sizes
   // ****************************************************************
   localparam int unsigned CRSEC_KEY_BYTES = 64;
   localparam int unsigned CRSEC_KEY_AW = 6;
   localparam int unsigned CRSEC_CODE_AW = 16;
   localparam logic [7:0] CRSEC_KEY_BLANK = 8'hFF;
   localparam logic [7:0] CRSEC_BYTE_ZERO = 8'h00;
   // Option byte: bit 0 fetch lock, bit 1 verify lock, 0 means enabled
   localparam int unsigned CRSEC_OPT_FETCH_BIT = 0;
   localparam int unsigned CRSEC_OPT_VERIFY_BIT = 1;
   localparam logic [7:0] CRSEC_OPT_RESET = 8'hFF;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [7:0] CRSEC_REG_CTRL = 8'h00;
   localparam logic [7:0] CRSEC_REG_ADDR = 8'h04;
   localparam logic [7:0] CRSEC_REG_DATA = 8'h08;
   localparam logic [7:0] CRSEC_REG_OPT = 8'h0C;
   localparam logic [7:0] CRSEC_REG_STAT = 8'h10;
   localparam logic [7:0] CRSEC_REG_VERIFY = 8'h14;
   // Control register commands (write value, bits 2:0)
   localparam logic [2:0] CRSEC_CMD_NONE = 3'h0;
   localparam logic [2:0] CRSEC_CMD_PGM_CODE = 3'h1;
   localparam logic [2:0] CRSEC_CMD_PGM_KEY = 3'h2;
   localparam logic [2:0] CRSEC_CMD_PGM_OPT = 3'h3;
   localparam logic [2:0] CRSEC_CMD_VERIFY = 3'h4;
   localparam logic [1:0] CRSEC_RESP_OKAY = 2'b00;
   localparam logic [1:0] CRSEC_RESP_SLVERR = 2'b10;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef enum logic [1:0] {
      CRSEC_IDLE = 2'b00,
      CRSEC_RESP = 2'b01
   } crsec_bus_e;

   // Code-memory port of the core
   typedef struct packed {
      logic pgm_en;
      logic [CRSEC_CODE_AW-1:0] addr;
      logic [7:0] wdata;
   } crsec_mem_req_s;

   // Fetch request from the core
   typedef struct packed {
      logic movc;
      logic from_external;
   } crsec_fetch_s;
endpackage : crsec_pkg

// ### hdl/crsec_top.sv
// Code-memory protection: lock bits, external-access latch, key scrambled verify, AXI4-Lite access
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module crsec_top
   import crsec_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic external_access_select_i,
   input wire crsec_fetch_s fetch_i,
   output logic fetch_block_o,
   output logic external_access_o,
   output crsec_mem_req_s mem_o,
   input wire logic [7:0] mem_rdata_i,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   typedef struct packed {
      logic [CRSEC_KEY_BYTES-1:0][7:0] key;
      logic [7:0] opt;
      logic ea_latch;
      logic ea_sampled;
      logic [CRSEC_CODE_AW-1:0] addr;
      logic [7:0] wdata;
      logic [7:0] verify;
      logic refused;
      logic pgm_en;
      logic aw_got;
      logic w_got;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      crsec_bus_e wr_st;
      logic [1:0] bresp;
      crsec_bus_e rd_st;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } crsec_state_s;

   crsec_state_s st_reg;
   crsec_state_s st_next;
   logic fetch_lock;
   logic verify_lock;
   logic wr_go;
   logic rd_go;
   logic [7:0] verify_byte;
   logic [3:0] stat_bits;

   // ****************************************************************
   // Lock decode
   // ****************************************************************
   assign fetch_lock = ~st_reg.opt[CRSEC_OPT_FETCH_BIT];
   // Undefined combination (verify lock alone) treated as verify lock only
   assign verify_lock = ~st_reg.opt[CRSEC_OPT_VERIFY_BIT];
   // Limitation: option byte and key stand for one-time cells but are blanked by every reset,
   // so a locked part comes back unlocked after the next reset

   // Only code-table reads run from external code are blocked; internal fetches always pass
   assign fetch_block_o = fetch_lock & fetch_i.movc & fetch_i.from_external;
   // Pin passes straight through when unlocked; latched value when locked
   assign external_access_o = fetch_lock ? st_reg.ea_latch : external_access_select_i;

   assign mem_o.pgm_en = st_reg.pgm_en;
   assign mem_o.addr = st_reg.addr;
   assign mem_o.wdata = st_reg.wdata;

   // Write runs one cycle after both halves are held, so address and data may come in either order
   assign wr_go = st_reg.aw_got & st_reg.w_got & (st_reg.wr_st == CRSEC_IDLE);
   assign rd_go = s_axi_arvalid & (st_reg.rd_st == CRSEC_IDLE);

   // One write and one read in flight at most; ready stays low while the answer stands
   assign s_axi_awready = ~st_reg.aw_got & (st_reg.wr_st == CRSEC_IDLE);
   assign s_axi_wready = ~st_reg.w_got & (st_reg.wr_st == CRSEC_IDLE);
   assign s_axi_bvalid = (st_reg.wr_st == CRSEC_RESP);
   assign s_axi_bresp = st_reg.bresp;
   assign s_axi_arready = (st_reg.rd_st == CRSEC_IDLE);
   assign s_axi_rvalid = (st_reg.rd_st == CRSEC_RESP);
   assign s_axi_rdata = st_reg.rdata;
   assign s_axi_rresp = st_reg.rresp;

   function automatic logic [7:0] crsec_lane(input logic [31:0] d, input logic [3:0] s, input logic [7:0] old);
      crsec_lane = s[0] ? d[7:0] : old;
   endfunction

   // ****************************************************************
   // Key scrambling and status
   // ****************************************************************
   // Key byte picked by the low address bits; the same pick serves programming and verify
   function automatic logic [CRSEC_KEY_AW-1:0] crsec_key_index(input logic [CRSEC_CODE_AW-1:0] a);
      crsec_key_index = a[CRSEC_KEY_AW-1:0];
   endfunction

   // Blank key byte is all ones, so XNOR leaves the code byte unchanged
   assign verify_byte = ~(mem_rdata_i ^ st_reg.key[crsec_key_index(st_reg.addr)]);
   assign stat_bits = {st_reg.ea_latch, verify_lock, fetch_lock, st_reg.refused};

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      st_next = st_reg;
      st_next.pgm_en = 1'b0;
      // Sampled once in the first cycle after reset release
      if (!st_reg.ea_sampled) begin
         st_next.ea_latch = external_access_select_i;
         st_next.ea_sampled = 1'b1;
      end
      if (s_axi_awvalid && s_axi_awready) begin
         st_next.aw_got = 1'b1;
         st_next.aw_addr = s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_next.w_got = 1'b1;
         st_next.w_data = s_axi_wdata;
         st_next.w_strb = s_axi_wstrb;
      end
      if (wr_go) begin
         st_next.aw_got = 1'b0;
         st_next.w_got = 1'b0;
         st_next.wr_st = CRSEC_RESP;
         st_next.bresp = CRSEC_RESP_OKAY;
         unique case (st_reg.aw_addr)
            CRSEC_REG_ADDR: begin
               if (st_reg.w_strb[0]) st_next.addr[7:0] = st_reg.w_data[7:0];
               if (st_reg.w_strb[1]) st_next.addr[15:8] = st_reg.w_data[15:8];
            end
            CRSEC_REG_DATA: st_next.wdata = crsec_lane(st_reg.w_data, st_reg.w_strb, st_reg.wdata);
            CRSEC_REG_CTRL: begin
               if (st_reg.w_strb[0]) begin
                  unique case (st_reg.w_data[2:0])
                     CRSEC_CMD_PGM_CODE: begin
                        if (fetch_lock) st_next.refused = 1'b1;
                        else st_next.pgm_en = 1'b1;
                     end
                     CRSEC_CMD_PGM_KEY: begin
                        if (fetch_lock) st_next.refused = 1'b1;
                        else st_next.key[crsec_key_index(st_reg.addr)] = st_reg.wdata;
                     end
                     // One-way: option bits only go from 1 to 0
                     CRSEC_CMD_PGM_OPT: st_next.opt = st_reg.opt & st_reg.wdata;
                     CRSEC_CMD_VERIFY: begin
                        if (verify_lock) begin
                           st_next.refused = 1'b1;
                           st_next.verify = CRSEC_BYTE_ZERO;
                        end else begin
                           // Only the scrambled byte leaves the block, never the key itself
                           st_next.verify = verify_byte;
                        end
                     end
                     default: st_next.refused = st_reg.refused;
                  endcase
               end
            end
            CRSEC_REG_STAT: begin
               // Write one clears the refusal flag
               if (st_reg.w_strb[0] && st_reg.w_data[0]) st_next.refused = 1'b0;
            end
            default: st_next.bresp = CRSEC_RESP_SLVERR;
         endcase
      end
      if (st_reg.wr_st == CRSEC_RESP && s_axi_bready) st_next.wr_st = CRSEC_IDLE;
      if (rd_go) begin
         st_next.rd_st = CRSEC_RESP;
         st_next.rresp = CRSEC_RESP_OKAY;
         st_next.rdata = '0;
         // Key is never mapped for reading
         unique case (s_axi_araddr[7:0])
            CRSEC_REG_CTRL: st_next.rdata = '0;
            CRSEC_REG_ADDR: st_next.rdata[15:0] = st_reg.addr;
            CRSEC_REG_DATA: st_next.rdata[7:0] = st_reg.wdata;
            CRSEC_REG_OPT: st_next.rdata[7:0] = st_reg.opt;
            CRSEC_REG_STAT: st_next.rdata[3:0] = stat_bits;
            CRSEC_REG_VERIFY: st_next.rdata[7:0] = st_reg.verify;
            default: st_next.rresp = CRSEC_RESP_SLVERR;
         endcase
      end
      if (st_reg.rd_st == CRSEC_RESP && s_axi_rready) st_next.rd_st = CRSEC_IDLE;
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // Key and option return to blank; the select latch reloads in the first cycle after release
         st_reg <= '0;
         st_reg.key <= {CRSEC_KEY_BYTES{CRSEC_KEY_BLANK}};
         st_reg.opt <= CRSEC_OPT_RESET;
         st_reg.wr_st <= CRSEC_IDLE;
         st_reg.rd_st <= CRSEC_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule // crsec_top

// ### sim/crsec_sva.sv
// Checker: bus and protection assertions for the code-memory protection block
`timescale 1ns/100ps
module crsec_sva
   import crsec_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire crsec_fetch_s fetch_i,
   input wire logic fetch_block_o,
   input wire logic external_access_o,
   input wire crsec_mem_req_s mem_o,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence both_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence read_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   chk_fetch_cause: assert property (fetch_block_o |-> fetch_i.movc && fetch_i.from_external)
      else $error("fetch block without external code-table read");
   // Once locked the latch must ignore the pin until the next reset; checked only in the cycle after a blocked fetch
   chk_ea_hold: assert property (fetch_block_o |=> $stable(external_access_o))
      else $error("external access changed while locked");
   chk_pgm_pulse: assert property (mem_o.pgm_en |=> !mem_o.pgm_en)
      else $error("program strobe longer than one cycle");
   chk_pgm_cause: assert property (mem_o.pgm_en |-> ##[0:1] s_axi_bvalid)
      else $error("program strobe not tied to a write");
   chk_write_answer: assert property (both_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   chk_read_answer: assert property (read_taken |=> s_axi_rvalid)
      else $error("read data late");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped or changed");
endmodule // crsec_sva
bind crsec_top crsec_sva chk_u (.clk_i(clk_i), .rst_i(rst_i), .fetch_i(fetch_i), .fetch_block_o(fetch_block_o),
   .external_access_o(external_access_o), .mem_o(mem_o), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata));

// ### sim/crsec_top_tb_top.sv
// Testbench: lock bits, key scrambling and bus access of the protection block
`timescale 1ns/100ps
module crsec_top_tb_top
   import crsec_pkg::*;
();
   logic clk_i = 0, rst_i = 1, ea_i = 1, fb_o, ea_o, awv = 0, awr, wv = 0, wr, bv, br = 0, arv = 0, arr, rv, rr = 0;
   logic [7:0] rd_i = 8'h00;
   logic [31:0] awa = '0, wd = '0, ara = '0, rdat, d;
   logic [1:0] bresp, rresp, r;
   crsec_fetch_s fetch_i = '0;
   crsec_mem_req_s mem_o, last_mem;
   int err_count = 0, check_count = 0, p, pulses = 0;
   // Image layout of the 8-kbyte part: key bytes follow the code
   localparam logic [31:0] IMG_KEY_BASE = 32'h2000;
   crsec_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .external_access_select_i(ea_i), .fetch_i(fetch_i),
      .fetch_block_o(fb_o), .external_access_o(ea_o), .mem_o(mem_o), .mem_rdata_i(rd_i), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
      .s_axi_rready(rr));
   initial forever #25 clk_i = ~clk_i;
   // Counted mid-cycle, where the strobe is settled, so the count is final when a write task returns
   always @(negedge clk_i) if (mem_o.pgm_en === 1'b1) begin
      pulses++;
      last_mem = mem_o;
   end
   // ****************************************************************
   // Bus tasks and comparison
   // ****************************************************************
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      awa <= 32'(a); wd <= v; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
      do begin
         @(posedge clk_i);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr) wv <= 1'b0;
      end while (!bv);
      br <= 1'b0; r = bresp;
   endtask
   task automatic axr(input logic [7:0] a);
      @(posedge clk_i);
      ara <= 32'(a); arv <= 1'b1; rr <= 1'b1;
      do begin
         @(posedge clk_i);
         if (arv && arr) arv <= 1'b0;
      end while (!rv);
      rr <= 1'b0; d = rdat; r = rresp;
   endtask
   task automatic verify_at(input logic [31:0] a);
      axw(CRSEC_REG_ADDR, a);
      axw(CRSEC_REG_CTRL, 32'(CRSEC_CMD_VERIFY));
      axr(CRSEC_REG_VERIFY);
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_plain;
      axr(CRSEC_REG_OPT); chk(32'(d[7:0]), 32'hFF);
      ea_i <= 1'b0; axr(CRSEC_REG_OPT); chk(32'(ea_o), 32'h0);
      axw(CRSEC_REG_ADDR, 32'h1234); axw(CRSEC_REG_DATA, 32'h5A); p = pulses;
      axw(CRSEC_REG_CTRL, 32'(CRSEC_CMD_PGM_CODE)); chk(pulses, p + 1);
      chk(32'({last_mem.addr, last_mem.wdata}), 32'h12345A);
      rd_i <= 8'hC3; verify_at(32'h1234); chk(d, 32'hC3);
   endtask
   task automatic t_key;
      // Key byte 34h of the image sits at key base plus 34h; its low bits pick the key byte
      axw(CRSEC_REG_ADDR, IMG_KEY_BASE + 32'h34);
      axw(CRSEC_REG_DATA, 32'h0F); axw(CRSEC_REG_CTRL, 32'(CRSEC_CMD_PGM_KEY)); p = pulses;
      verify_at(32'h1234); chk(d, 32'h33);
      verify_at(32'h003F); chk(d, 32'hC3);
      chk(pulses, p);
   endtask
   task automatic t_lock1;
      ea_i <= 1'b1;
      axw(CRSEC_REG_DATA, 32'hFE); axw(CRSEC_REG_CTRL, 32'(CRSEC_CMD_PGM_OPT));
      fetch_i <= crsec_fetch_s'(2'b11);
      axr(CRSEC_REG_OPT); chk(32'(d[7:0]), 32'hFE);
      chk(32'(fb_o), 32'h1);
      ea_i <= 1'b0; axr(CRSEC_REG_OPT); chk(32'(ea_o), 32'h1);
      fetch_i <= crsec_fetch_s'(2'b10); axr(CRSEC_REG_OPT); chk(32'(fb_o), 32'h0);
      p = pulses; axw(CRSEC_REG_CTRL, 32'(CRSEC_CMD_PGM_CODE)); chk(pulses, p);
      axr(CRSEC_REG_STAT); chk(32'(d[0]), 32'h1);
      axr(8'h40); chk(32'(r), 32'(CRSEC_RESP_SLVERR));
   endtask
   task automatic t_lock2;
      // Verify lock is set here on top of the fetch lock already in place
      axw(CRSEC_REG_STAT, 32'h1); axw(CRSEC_REG_DATA, 32'hFC); axw(CRSEC_REG_CTRL, 32'(CRSEC_CMD_PGM_OPT));
      verify_at(32'h1234); chk(d, 32'h0);
      axr(CRSEC_REG_STAT); chk(32'(d[0]), 32'h1);
   endtask
   task automatic end_of_test;
      $display("Mismatches %0d of %0d comparisons", err_count, check_count);
      if (err_count == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Pin reads high during reset, so the latch later holds 1 (expected 0 above is the unlocked follow)
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_plain; t_key; t_lock1; t_lock2;
      end_of_test;
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      err_count++;
      end_of_test;
   end
endmodule // crsec_top_tb_top
